// ---- rtl/psl_pkg.sv ----
// shared types and constants for the serial load port and rf fastlock control
// assumes a 24-bit word shifted msb first, select field in the two lowest bits
package psl_pkg;

    localparam int WORD_W  = 24;
    localparam int SEL_W   = 2;
    localparam int PUMP_W  = 3;

    // latch select codes
    localparam logic [1:0] SEL_IF_REF = 2'h0;
    localparam logic [1:0] SEL_IF_DIV = 2'h1;
    localparam logic [1:0] SEL_RF_REF = 2'h2;
    localparam logic [1:0] SEL_RF_DIV = 2'h3;

    // pump current code position inside the rf reference latch
    localparam int PUMP_LSB = 18;
    localparam logic [PUMP_W-1:0] PUMP_MAX = 3'h7;

    localparam logic [WORD_W-1:0] WORD_RST  = 24'h000000;
    localparam logic [3:0]        SEEN_RST  = 4'h0;
    localparam logic [3:0]        SEEN_ALL  = 4'hF;

    typedef struct packed {
        logic [21:0] payload;
        logic [1:0]  latch_select_field;
    } psl_word_t;

    typedef struct packed {
        logic        rf_gain_boost_bit;
        logic        power_down;
        logic [1:0]  prescaler;
        logic [11:0] prog_count;
        logic [5:0]  swallow_count;
        logic [1:0]  latch_select_field;
    } psl_rf_div_t;

    typedef struct packed {
        psl_word_t   if_ref;
        psl_word_t   if_div;
        psl_word_t   rf_ref;
        psl_rf_div_t rf_div;
    } psl_latches_t;

endpackage

// ---- rtl/psl_top.sv ----
// serial load port: shift register on the serial clock, four latches on clk
// assumes the host stops the serial clock while load_strobe is high,
// so the shift register is stable when the system side copies it
// Notes on behaviour
// - fastlock only while gain-boost bit is one
// - fastlock forces maximum rf pump current
// - fastlock grounds damping resistor via switch pin
// - divide values and fastlock commit together
// - data sampled on every rising serial clock
// - strobe rise copies word into selected latch
// - two select bits choose one of four latches
// - rf divider holds swallow, counter, prescaler, flags
`timescale 1ns/10ps
`default_nettype none
module psl_top (
    input  wire logic                           clk,                  // system clock, 40 MHz
    input  wire logic                           rst_n,                // sync reset, active low
    input  wire logic                           sclk,                 // serial clock from host
    input  wire logic                           sdata,                // serial data from host
    input  wire logic                           load_strobe,          // commit strobe, async pin
    output logic           [psl_pkg::WORD_W-1:0] shift_word,          // shift register, sclk domain
    output psl_pkg::psl_latches_t               latches,              // committed latches
    output logic                                outputs_active,       // all four latches written
    output logic                                fastlock_active,      // rf fastlock in force
    output logic           [psl_pkg::PUMP_W-1:0] rf_pump_current,     // effective pump code
    output logic                                fastlock_switch_pin_o, // pin level, always low
    output logic                                fastlock_switch_pin_oe // high grounds resistor
);

    // serial clock domain
    logic [psl_pkg::WORD_W-1:0] shift_q;
    logic [psl_pkg::WORD_W-1:0] shift_d;

    always_comb begin
        shift_d = {shift_q[psl_pkg::WORD_W-2:0], sdata};
    end

    always_ff @(posedge sclk) begin
        shift_q <= shift_d;
    end

    assign shift_word = shift_q;

    // check helper: sclk edges since reset, saturating one past a word;
    // the shift register has no reset, so the bit check waits one edge and the order check until it is full
    localparam logic [4:0] FILL_TOP = 5'(psl_pkg::WORD_W + 1);
    logic       fill_clr_q;
    logic       fill_clr_d;
    logic [4:0] fill_q;
    logic [4:0] fill_d;

    always_comb begin
        fill_clr_d = !rst_n;
    end

    always_ff @(posedge clk) begin
        fill_clr_q <= fill_clr_d;
    end

    always_comb begin
        fill_d = fill_q;
        if (fill_q != FILL_TOP) begin
            fill_d = fill_q + 5'h01;
        end
    end

    // async clear is safe only because the host keeps sclk stopped around reset
    always_ff @(posedge sclk or posedge fill_clr_q) begin
        if (fill_clr_q) begin
            fill_q <= 5'h00;
        end else begin
            fill_q <= fill_d;
        end
    end

    // system clock domain
    logic                       le_s1_q;
    logic                       le_s2_q;
    logic                       le_s3_q;
    logic                       commit;
    psl_pkg::psl_latches_t      lat_q;
    psl_pkg::psl_latches_t      lat_d;
    logic [3:0]                 seen_q;
    logic [3:0]                 seen_d;
    logic                       fast_q;
    logic                       fast_d;
    logic [psl_pkg::PUMP_W-1:0] pump_q;
    logic [psl_pkg::PUMP_W-1:0] pump_d;
    psl_pkg::psl_word_t         word_in;

    // strobe rise acts as request; word is held still by the stopped sclk
    assign commit  = le_s2_q & ~le_s3_q;
    assign word_in = psl_pkg::psl_word_t'(shift_q);

    always_comb begin
        lat_d  = lat_q;
        seen_d = seen_q;
        if (commit) begin
            if (word_in.latch_select_field == psl_pkg::SEL_IF_REF) begin
                lat_d.if_ref = word_in;
                seen_d[0]    = 1'b1;
            end else if (word_in.latch_select_field == psl_pkg::SEL_IF_DIV) begin
                lat_d.if_div = word_in;
                seen_d[1]    = 1'b1;
            end else if (word_in.latch_select_field == psl_pkg::SEL_RF_REF) begin
                lat_d.rf_ref = word_in;
                seen_d[2]    = 1'b1;
            end else begin
                lat_d.rf_div = psl_pkg::psl_rf_div_t'(shift_q);
                seen_d[3]    = 1'b1;
            end
        end
        fast_d = lat_d.rf_div.rf_gain_boost_bit;
        if (fast_d) begin
            pump_d = psl_pkg::PUMP_MAX;
        end else begin
            pump_d = lat_d.rf_ref.payload[psl_pkg::PUMP_LSB-psl_pkg::SEL_W +: psl_pkg::PUMP_W];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            le_s1_q <= 1'b0;
            le_s2_q <= 1'b0;
            le_s3_q <= 1'b0;
            lat_q   <= psl_pkg::psl_latches_t'({4{psl_pkg::WORD_RST}});
            seen_q  <= psl_pkg::SEEN_RST;
            fast_q  <= 1'b0;
            pump_q  <= '0;
        end else begin
            le_s1_q <= load_strobe;
            le_s2_q <= le_s1_q;
            le_s3_q <= le_s2_q;
            lat_q   <= lat_d;
            seen_q  <= seen_d;
            fast_q  <= fast_d;
            pump_q  <= pump_d;
        end
    end

    assign latches               = lat_q;
    assign outputs_active        = (seen_q == psl_pkg::SEEN_ALL);
    assign fastlock_active       = fast_q;
    assign rf_pump_current       = pump_q;
    assign fastlock_switch_pin_o  = 1'b0;
    assign fastlock_switch_pin_oe = fast_q;

    AST_SHIFT_IN: assert property (@(posedge sclk)
        fill_q != 5'h00 |-> shift_q[0] == $past(sdata))
        else $error("serial bit not sampled");

    AST_SHIFT_ORDER: assert property (@(posedge sclk)
        fill_q == FILL_TOP
        |-> shift_q[psl_pkg::WORD_W-1:1] == $past(shift_q[psl_pkg::WORD_W-2:0]))
        else $error("shift order wrong");

    AST_FAST_ONLY_BOOST: assert property (@(posedge clk) disable iff (!rst_n)
        fastlock_active == lat_q.rf_div.rf_gain_boost_bit)
        else $error("fastlock disagrees with gain bit");

    AST_PUMP_MAX: assert property (@(posedge clk) disable iff (!rst_n)
        fastlock_active |-> rf_pump_current == psl_pkg::PUMP_MAX)
        else $error("pump not at maximum in fastlock");

    AST_PIN_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
        fastlock_switch_pin_oe == fastlock_active && !fastlock_switch_pin_o)
        else $error("switch pin not following fastlock");

    AST_TOGETHER: assert property (@(posedge clk) disable iff (!rst_n)
        commit && word_in.latch_select_field == psl_pkg::SEL_RF_DIV
        |=> lat_q.rf_div == psl_pkg::psl_rf_div_t'($past(shift_q))
            && fastlock_active == $past(shift_q[psl_pkg::WORD_W-1]))
        else $error("divider and fastlock not applied together");

    AST_COMMIT_SEL: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(le_s2_q) && word_in.latch_select_field == psl_pkg::SEL_IF_REF
        |=> latches.if_ref == $past(word_in) && $stable(latches.rf_div))
        else $error("if reference latch not loaded");

    AST_NO_COMMIT: assert property (@(posedge clk) disable iff (!rst_n)
        !commit |=> $stable(lat_q))
        else $error("latch changed without strobe");

    AST_STROBE_DELAY: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(le_s1_q) && le_s2_q == 1'b0 ##1 le_s1_q |-> commit)
        else $error("strobe rise not committed");

    AST_RF_FIELDS: assert property (@(posedge clk) disable iff (!rst_n)
        lat_q.rf_div.latch_select_field == psl_pkg::SEL_RF_DIV || !seen_q[3])
        else $error("rf divider latch holds wrong word");

    AST_PUMP_CODE: assert property (@(posedge clk) disable iff (!rst_n)
        !fastlock_active |-> rf_pump_current == latches.rf_ref[psl_pkg::PUMP_LSB +: psl_pkg::PUMP_W])
        else $error("pump code not the programmed one");

    AST_PIN_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(fastlock_active) |-> !fastlock_switch_pin_oe)
        else $error("switch pin not released after fastlock");

    AST_KEEP_OTHERS: assert property (@(posedge clk) disable iff (!rst_n)
        commit && word_in.latch_select_field == psl_pkg::SEL_RF_DIV
        |=> $stable(latches.if_ref) && $stable(latches.if_div) && $stable(latches.rf_ref))
        else $error("unselected latch changed");

    AST_COMMIT_RF_REF: assert property (@(posedge clk) disable iff (!rst_n)
        commit && word_in.latch_select_field == psl_pkg::SEL_RF_REF
        |=> latches.rf_ref == $past(word_in))
        else $error("rf reference latch not loaded");

    AST_COMMIT_IF_DIV: assert property (@(posedge clk) disable iff (!rst_n)
        commit && word_in.latch_select_field == psl_pkg::SEL_IF_DIV
        |=> latches.if_div == $past(word_in))
        else $error("if divider latch not loaded");

    COV_IF_REF: cover property (@(posedge clk) disable iff (!rst_n)
        commit && word_in.latch_select_field == psl_pkg::SEL_IF_REF);
    COV_RF_DIV: cover property (@(posedge clk) disable iff (!rst_n)
        commit && word_in.latch_select_field == psl_pkg::SEL_RF_DIV);
    COV_FAST_ON_OFF: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(fastlock_active) ##[1:300] $fell(fastlock_active));
    COV_ALL_SEEN: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(outputs_active));

endmodule
`default_nettype wire

// ---- tb/psl_host.sv ----
// host serial master model driving the load port pins
// assumes clk is the device system clock; sclk stands low outside words
`timescale 1ns/10ps
`default_nettype none
module psl_host (
    input  wire logic clk,        // system clock, paces the strobe
    output logic      sclk,       // serial clock, 12 ns within words
    output logic      sdata,      // serial data
    output logic      load_strobe // commit strobe
);
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        load_strobe = 1'b0;
    end
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            sdata = w[i];
            // 6 ns half period; logic has no rate floor
            #6 sclk = 1'b1;
            #6 sclk = 1'b0;
        end
        // idle data shows the inverse, not a stale bit
        sdata = ~w[0];
        repeat (2) @(negedge clk);
        load_strobe = 1'b1;
        repeat (6) @(negedge clk);
        load_strobe = 1'b0;
        repeat (3) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// ---- tb/pll_serial_load_fastlock_tb.sv ----
// self-checking bench: host model writes words, a queue-free model checks
// assumes psl_top and psl_host; the link clock runs only inside words
`timescale 1ns/10ps
`default_nettype none
module pll_serial_load_fastlock_tb;
    logic                  clk = 1'b0;
    logic                  rst_n;
    logic                  sclk;
    logic                  sdata;
    logic                  load_strobe;
    logic [23:0]           shift_word;
    psl_pkg::psl_latches_t latches;
    logic                  outputs_active;
    logic                  fastlock_active;
    logic [2:0]            rf_pump_current;
    logic                  pin_o;
    logic                  pin_oe;
    int                    n_mismatch = 0;
    int                    n_compared = 0;
    int                    cycles = 0;
    logic [23:0]           lat [4];
    logic [3:0]            seen;
    always #12.5 clk = ~clk;
    psl_host host (.clk(clk), .sclk(sclk), .sdata(sdata), .load_strobe(load_strobe));
    psl_top uut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .sdata(sdata),
        .load_strobe(load_strobe), .shift_word(shift_word), .latches(latches),
        .outputs_active(outputs_active), .fastlock_active(fastlock_active),
        .rf_pump_current(rf_pump_current), .fastlock_switch_pin_o(pin_o),
        .fastlock_switch_pin_oe(pin_oe));
    task automatic check(input string what, input logic [23:0] e, input logic [23:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic results();
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check_all();
        logic b;
        b = lat[3][23];
        check("if_ref", lat[0], latches.if_ref);
        check("if_div", lat[1], latches.if_div);
        check("rf_ref", lat[2], latches.rf_ref);
        check("rf_div", lat[3], latches.rf_div);
        check("outputs_active", {23'h0, &seen}, {23'h0, outputs_active});
        check("fastlock_active", {23'h0, b}, {23'h0, fastlock_active});
        check("pump", b ? 24'h7 : {21'h0, lat[2][20:18]}, {21'h0, rf_pump_current});
        check("pin_oe", {23'h0, b}, {23'h0, pin_oe});
        check("pin_o", 24'h0, {23'h0, pin_o});
    endtask
    task automatic wr(input logic [21:0] p, input logic [1:0] s);
        host.send({p, s});
        lat[s] = {p, s};
        seen[s] = 1'b1;
        check("shift_word", {p, s}, shift_word);
        check_all();
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        lat = '{default: 24'h0};
        seen = 4'h0;
        check_all();
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        void'($urandom(11545));
        do_reset();
        // each select once, fourth raises active
        for (int s = 0; s < 4; s++) wr(22'($urandom), 2'(s));
        wr({1'b1, 21'($urandom)}, psl_pkg::SEL_RF_DIV);
        wr(22'($urandom), psl_pkg::SEL_RF_REF);
        wr({1'b1, 21'($urandom)}, psl_pkg::SEL_RF_DIV);
        // host clears boost to leave fastlock
        wr({1'b0, 21'($urandom)}, psl_pkg::SEL_RF_DIV);
        wr(22'($urandom), psl_pkg::SEL_IF_DIV);
        do_reset();
        wr({1'b1, 21'($urandom)}, psl_pkg::SEL_RF_DIV);
        results();
    end
endmodule
`default_nettype wire
